// ==== rtl/ep_host_ctrl.sv ====
// firmware-side controller for one single-bank usb control endpoint
// What this block does
// - control traffic only on single-bank endpoints; a go is refused on a two-bank endpoint, but its setups are still read
// - isochronous only on ping-pong endpoints
// - host sends zero-length status out packet
// - read whole setup packet before clearing
// - arguments follow in out, results in in
// - service received setup as soon as possible
// - check packet-ready clear before loading fifo
// - load payload by successive byte writes
// - set packet-ready after loading the fifo
// - clear completion after arming next packet
// - clear completion after the final packet
// - fifo accessed by byte-wide register transfers
`timescale 1ns/100ps
module ep_host_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave for software
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ep_host_pkg::ADDR_W-1:0] paddr,
  input wire logic [ep_host_pkg::DATA_W-1:0] pwdata,
  output logic [ep_host_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // apb master toward the device
  output logic dev_psel,
  output logic dev_penable,
  output logic dev_pwrite,
  output logic [ep_host_pkg::ADDR_W-1:0] dev_paddr,
  output logic [ep_host_pkg::DATA_W-1:0] dev_pwdata,
  input wire logic [ep_host_pkg::DATA_W-1:0] dev_prdata,
  input wire logic dev_pready
);
  import ep_host_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_POLL = 4'h1,
    S_EVAL = 4'h2,
    S_SETUP_RD = 4'h3,
    S_SETUP_CLR = 4'h4,
    S_TX_LOAD = 4'h5,
    S_TX_ARM = 4'h6,
    S_TX_CLR = 4'h7
  } seq_state_type;

  localparam int IDX_W = $clog2(MAX_PKT);

  // device register address of one endpoint
  function automatic logic [ADDR_W-1:0] dev_addr(
    input logic [ADDR_W-1:0] base,
    input logic [EP_W-1:0] ep
  );
    dev_addr = base + {{(ADDR_W-EP_W-2){1'b0}}, ep, 2'b00};
  endfunction : dev_addr

  seq_state_type state;
  tx_phase_type tx_phase;
  logic [EP_W-1:0] ep_sel;
  logic [LEN_W-1:0] len_reg;
  logic [LEN_W-1:0] tx_len;
  logic [LEN_W-1:0] cnt;
  logic tx_queued;
  logic clr_pending;
  logic setup_valid;
  logic tx_done;
  logic refused;
  logic [DATA_W-1:0] csr_shadow;
  logic [7:0] setup_bytes [SETUP_BYTES];
  logic [7:0] buf_mem [MAX_PKT];
  logic issued;
  logic m_req;
  logic m_write;
  logic [ADDR_W-1:0] m_addr;
  logic [DATA_W-1:0] m_wdata;
  logic m_done;
  logic [DATA_W-1:0] m_rdata;

  logic acc;
  logic wr_en;
  logic is_buf;
  logic mapped;
  logic [IDX_W-1:0] buf_idx;
  logic go_wr;
  logic go_ok;
  logic ep_pingpong;
  logic ev_setup_done;
  logic ev_armed;
  logic ev_final_clr;
  logic issue_state;
  logic next_write;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_wdata;
  logic [DATA_W-1:0] rd_val;

  // software bus decode
  assign acc = psel & penable & pready;
  assign wr_en = acc & pwrite;
  assign is_buf = (paddr[11:8] == BUF_PAGE);
  assign buf_idx = paddr[2 +: IDX_W];
  assign mapped = is_buf | (paddr == CTRL_OFFSET) | (paddr == LEN_OFFSET)
    | (paddr == STAT_OFFSET) | (paddr == SETUP_LO_OFFSET)
    | (paddr == SETUP_HI_OFFSET);
  assign go_wr = wr_en & (paddr == CTRL_OFFSET) & pwdata[CTRL_GO_BIT];
  assign ep_pingpong = PINGPONG_EP_MASK[pwdata[CTRL_EP_LSB +: EP_W]];
  // a go is taken when idle, or queued behind a packet awaiting its ack
  assign go_ok = go_wr & ~ep_pingpong
    & ((tx_phase == TX_NONE) | ((tx_phase == TX_WAIT) & ~tx_queued));

  // sequencer events seen by the bookkeeping blocks
  assign ev_setup_done = (state == S_SETUP_CLR) & m_done;
  assign ev_armed = (state == S_TX_ARM) & m_done;
  assign ev_final_clr = (state == S_TX_CLR) & m_done & ~clr_pending;

  // apb slave handshake, one wait cycle per access
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rd_val = '0;
    if (is_buf) begin
      rd_val[7:0] = buf_mem[buf_idx];
    end else if (paddr == CTRL_OFFSET) begin
      rd_val[CTRL_EP_LSB +: EP_W] = ep_sel;
    end else if (paddr == LEN_OFFSET) begin
      rd_val[LEN_W-1:0] = len_reg;
    end else if (paddr == STAT_OFFSET) begin
      rd_val[STAT_BUSY_BIT] = (tx_phase != TX_NONE);
      rd_val[STAT_SETUP_BIT] = setup_valid;
      rd_val[STAT_DONE_BIT] = tx_done;
      rd_val[STAT_REFUSED_BIT] = refused;
      rd_val[STAT_QUEUED_BIT] = tx_queued;
      rd_val[STAT_STATE_LSB +: 4] = state;
    end else if (paddr == SETUP_LO_OFFSET) begin
      rd_val = {setup_bytes[3], setup_bytes[2], setup_bytes[1],
        setup_bytes[0]};
    end else if (paddr == SETUP_HI_OFFSET) begin
      rd_val = {setup_bytes[7], setup_bytes[6], setup_bytes[5],
        setup_bytes[4]};
    end
  end

  // endpoint and length registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ep_sel <= EP_RESET;
      len_reg <= LEN_RESET;
    end else begin
      // endpoint only moves while no packet is in flight
      if (wr_en & (paddr == CTRL_OFFSET) & (tx_phase == TX_NONE)) begin
        ep_sel <= pwdata[CTRL_EP_LSB +: EP_W];
      end
      if (wr_en & (paddr == LEN_OFFSET)) begin
        len_reg <= (pwdata[LEN_W-1:0] > LEN_W'(MAX_PKT)) ?
          LEN_W'(MAX_PKT) : pwdata[LEN_W-1:0];
      end
    end
  end

  // payload buffer, one byte per word
  always_ff @(posedge clk_sys) begin
    if (wr_en & is_buf) begin
      buf_mem[buf_idx] <= pwdata[7:0];
    end
  end

  // sticky status flags; hardware set wins over software clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      setup_valid <= 1'b0;
      tx_done <= 1'b0;
      refused <= 1'b0;
    end else begin
      if (ev_setup_done) begin
        setup_valid <= 1'b1;
      end else if (wr_en & (paddr == STAT_OFFSET) & pwdata[STAT_SETUP_BIT]) begin
        setup_valid <= 1'b0;
      end
      if (ev_final_clr) begin
        tx_done <= 1'b1;
      end else if (wr_en & (paddr == STAT_OFFSET) & pwdata[STAT_DONE_BIT]) begin
        tx_done <= 1'b0;
      end
      if (go_wr & ~go_ok) begin
        refused <= 1'b1;
      end else if (wr_en & (paddr == STAT_OFFSET)
          & pwdata[STAT_REFUSED_BIT]) begin
        refused <= 1'b0;
      end
    end
  end

  // packet bookkeeping: one in flight, one queued behind it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_phase <= TX_NONE;
      tx_queued <= 1'b0;
      tx_len <= LEN_RESET;
    end else begin
      if (go_ok & (tx_phase == TX_NONE)) begin
        tx_phase <= TX_LOAD;
        tx_len <= len_reg;
      end else if (go_ok) begin
        tx_queued <= 1'b1;
        tx_len <= len_reg;
      end else if (ev_armed) begin
        tx_phase <= TX_WAIT;
        tx_queued <= 1'b0;
      end else if (ev_final_clr) begin
        tx_phase <= TX_NONE;
      end
    end
  end

  // which states drive a device access, and with what
  always_comb begin
    issue_state = 1'b1;
    next_write = 1'b1;
    next_addr = dev_addr(DEV_CSR_BASE, ep_sel);
    next_wdata = csr_shadow;
    unique case (state)
      S_POLL: begin
        next_write = 1'b0;
      end
      S_SETUP_RD: begin
        next_write = 1'b0;
        next_addr = dev_addr(DEV_FDR_BASE, ep_sel);
      end
      S_SETUP_CLR: begin
        next_wdata[SETUP_RECEIVED_BIT] = 1'b0;
      end
      S_TX_LOAD: begin
        next_addr = dev_addr(DEV_FDR_BASE, ep_sel);
        next_wdata = {24'h000000, buf_mem[cnt[IDX_W-1:0]]};
      end
      S_TX_ARM: begin
        next_wdata[TX_PACKET_READY_BIT] = 1'b1;
      end
      S_TX_CLR: begin
        next_wdata[TX_COMPLETE_BIT] = 1'b0;
      end
      default: begin
        issue_state = 1'b0;
      end
    endcase
  end

  // request launch toward the bus master
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      issued <= 1'b0;
      m_req <= 1'b0;
      m_write <= 1'b0;
      m_addr <= '0;
      m_wdata <= '0;
    end else begin
      m_req <= 1'b0;
      if (m_done) begin
        issued <= 1'b0;
      end else if (issue_state & ~issued) begin
        issued <= 1'b1;
        m_req <= 1'b1;
        m_write <= next_write;
        m_addr <= next_addr;
        m_wdata <= next_wdata;
      end
    end
  end

  // sequencer; polls the endpoint whenever no sequence is running, so setups are seen between packets
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= S_IDLE;
      cnt <= '0;
      clr_pending <= 1'b0;
      csr_shadow <= '0;
      setup_bytes <= '{default: 8'h00};
    end else begin
      unique case (state)
        S_IDLE: begin
          state <= S_POLL;
        end
        S_POLL: begin
          if (m_done) begin
            csr_shadow <= m_rdata;
            state <= S_EVAL;
          end
        end
        S_EVAL: begin
          cnt <= '0;
          if (csr_shadow[SETUP_RECEIVED_BIT] & ~setup_valid) begin
            state <= S_SETUP_RD;
          end else if ((tx_phase == TX_LOAD)
              & ~csr_shadow[TX_PACKET_READY_BIT]) begin
            clr_pending <= 1'b0;
            state <= (tx_len == '0) ? S_TX_ARM : S_TX_LOAD;
          end else if ((tx_phase == TX_WAIT)
              & csr_shadow[TX_COMPLETE_BIT]) begin
            // fifo released with the ack; next packet first, then clear
            if (tx_queued) begin
              clr_pending <= 1'b1;
              state <= (tx_len == '0) ? S_TX_ARM : S_TX_LOAD;
            end else begin
              clr_pending <= 1'b0;
              state <= S_TX_CLR;
            end
          end else begin
            state <= S_IDLE;
          end
        end
        S_SETUP_RD: begin
          if (m_done) begin
            setup_bytes[cnt[2:0]] <= m_rdata[7:0];
            cnt <= cnt + 1'b1;
            // whole packet read before the flag is released
            if (cnt == LEN_W'(SETUP_BYTES - 1)) begin
              state <= S_SETUP_CLR;
            end
          end
        end
        S_SETUP_CLR: begin
          if (m_done) begin
            csr_shadow[SETUP_RECEIVED_BIT] <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_TX_LOAD: begin
          if (m_done) begin
            cnt <= cnt + 1'b1;
            if (cnt == tx_len - 1'b1) begin
              state <= S_TX_ARM;
            end
          end
        end
        S_TX_ARM: begin
          if (m_done) begin
            csr_shadow[TX_PACKET_READY_BIT] <= 1'b1;
            state <= clr_pending ? S_TX_CLR : S_IDLE;
          end
        end
        S_TX_CLR: begin
          if (m_done) begin
            csr_shadow[TX_COMPLETE_BIT] <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // device register access engine
  dev_bus_master u_master (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .req(m_req),
    .req_write(m_write),
    .req_addr(m_addr),
    .req_wdata(m_wdata),
    .done(m_done),
    .rdata(m_rdata),
    .psel(dev_psel),
    .penable(dev_penable),
    .pwrite(dev_pwrite),
    .paddr(dev_paddr),
    .pwdata(dev_pwdata),
    .prdata(dev_prdata),
    .pready(dev_pready)
  );
endmodule : ep_host_ctrl

// ==== shared/ep_host_pkg.sv ====
// constants shared by the endpoint host controller and its bus master
package ep_host_pkg;
  // widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int LEN_W = 7;
  localparam int EP_W = 3;
  localparam int SETUP_BYTES = 8;
  localparam int MAX_PKT = 64;
  // offsets of our own software registers
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] LEN_OFFSET = 12'h004;
  localparam logic [11:0] STAT_OFFSET = 12'h008;
  localparam logic [11:0] SETUP_LO_OFFSET = 12'h00c;
  localparam logic [11:0] SETUP_HI_OFFSET = 12'h010;
  localparam logic [3:0] BUF_PAGE = 4'h1;
  // control register fields
  localparam int CTRL_EP_LSB = 0;
  localparam int CTRL_GO_BIT = 8;
  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SETUP_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;
  localparam int STAT_QUEUED_BIT = 4;
  localparam int STAT_STATE_LSB = 8;
  // device endpoint register map
  localparam logic [11:0] DEV_CSR_BASE = 12'h030;
  localparam logic [11:0] DEV_FDR_BASE = 12'h050;
  // device endpoint control/status bit positions
  localparam int TX_COMPLETE_BIT = 0;
  localparam int SETUP_RECEIVED_BIT = 2;
  localparam int TX_PACKET_READY_BIT = 4;
  // endpoints built with two banks (ping-pong)
  localparam logic [7:0] PINGPONG_EP_MASK = 8'hf6;
  // reset values
  localparam logic [LEN_W-1:0] LEN_RESET = 7'h00;
  localparam logic [EP_W-1:0] EP_RESET = 3'h0;

  typedef enum logic [1:0] {
    TX_NONE = 2'b00,
    TX_LOAD = 2'b01,
    TX_WAIT = 2'b10
  } tx_phase_type;
endpackage : ep_host_pkg

// ==== rtl/dev_bus_master.sv ====
// apb master that runs one device register access per request
`timescale 1ns/100ps
module dev_bus_master (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // request from the sequencer
  input wire logic req,
  input wire logic req_write,
  input wire logic [ep_host_pkg::ADDR_W-1:0] req_addr,
  input wire logic [ep_host_pkg::DATA_W-1:0] req_wdata,
  output logic done,
  output logic [ep_host_pkg::DATA_W-1:0] rdata,
  // apb toward the device
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ep_host_pkg::ADDR_W-1:0] paddr,
  output logic [ep_host_pkg::DATA_W-1:0] pwdata,
  input wire logic [ep_host_pkg::DATA_W-1:0] prdata,
  input wire logic pready
);
  import ep_host_pkg::*;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_SETUP = 2'b01,
    M_ACCESS = 2'b10
  } master_state_type;

  master_state_type state;

  // setup then access, held until the device answers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= M_IDLE;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= '0;
      pwdata <= '0;
      done <= 1'b0;
      rdata <= '0;
    end else begin
      done <= 1'b0;
      unique case (state)
        M_IDLE: begin
          if (req) begin
            psel <= 1'b1;
            pwrite <= req_write;
            paddr <= req_addr;
            pwdata <= req_wdata;
            state <= M_SETUP;
          end
        end
        M_SETUP: begin
          penable <= 1'b1;
          state <= M_ACCESS;
        end
        M_ACCESS: begin
          // no timeout: a silent device stalls the sequencer
          if (pready) begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b1;
            rdata <= prdata;
            state <= M_IDLE;
          end
        end
        default: state <= M_IDLE;
      endcase
    end
  end
endmodule : dev_bus_master

// ==== tb/ep_host_ctrl_sva.sv ====
// assertion checker for the endpoint host controller ports
`timescale 1ns/100ps
module ep_host_ctrl_sva import ep_host_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // software apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ep_host_pkg::ADDR_W-1:0] paddr,
  input wire logic [ep_host_pkg::DATA_W-1:0] pwdata,
  input wire logic [ep_host_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // device apb
  input wire logic dev_psel,
  input wire logic dev_penable,
  input wire logic dev_pwrite,
  input wire logic [ep_host_pkg::ADDR_W-1:0] dev_paddr,
  input wire logic [ep_host_pkg::DATA_W-1:0] dev_pwdata,
  input wire logic [ep_host_pkg::DATA_W-1:0] dev_prdata,
  input wire logic dev_pready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [2:0] fifo_ep;
  logic fifo_wr;
  logic pkt_busy;
  // endpoint of a fifo access, the csr stride is shared
  assign fifo_ep = 3'((dev_paddr - DEV_FDR_BASE) >> 2);
  assign fifo_wr = dev_psel && dev_pwrite && dev_paddr >= DEV_FDR_BASE;
  // last packet-ready state the controller saw or wrote
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      pkt_busy <= 1'b0;
    else if (dev_psel && dev_penable && dev_pready
             && dev_paddr < DEV_FDR_BASE)
      pkt_busy <= dev_pwrite ? dev_pwdata[TX_PACKET_READY_BIT]
                             : dev_prdata[TX_PACKET_READY_BIT];
  end
  property p_rdy_pulse;
    pready |-> psel && penable ##1 !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready not a pulse");
  property p_rdy_wait;
    $rose(penable) && psel |=> pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
  property p_err_zero;
    pslverr |-> pready && (pwrite || prdata == 32'h0);
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad error answer");
  property p_dev_order;
    $rose(dev_psel) |-> !dev_penable ##1 dev_penable;
  endproperty
  a_dev_order: assert property (p_dev_order) else $error("no setup phase");
  property p_dev_hold;
    dev_psel && !(dev_penable && dev_pready) |=> $stable(dev_paddr) &&
      $stable(dev_pwrite) && $stable(dev_pwdata) && dev_psel;
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("request dropped");
  property p_dev_idle;
    dev_psel && dev_penable && dev_pready |=> !dev_psel;
  endproperty
  a_dev_idle: assert property (p_dev_idle) else $error("no idle cycle");
  property p_fifo_byte;
    fifo_wr |-> dev_pwdata[31:8] == 24'h0;
  endproperty
  a_fifo_byte: assert property (p_fifo_byte) else $error("wide fifo write");
  property p_single_bank;
    fifo_wr |-> !PINGPONG_EP_MASK[fifo_ep];
  endproperty
  a_single_bank: assert property (p_single_bank) else $error("two-bank load");
  property p_load_free;
    fifo_wr |-> !pkt_busy;
  endproperty
  a_load_free: assert property (p_load_free) else $error("load while armed");
  c_err: cover property (pslverr);
  c_load: cover property (fifo_wr);
  c_arm: cover property (dev_psel && dev_pwrite && dev_pwdata[4] && !fifo_wr);
endmodule : ep_host_ctrl_sva

bind ep_host_ctrl ep_host_ctrl_sva chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dev_psel(dev_psel), .dev_penable(dev_penable), .dev_pwrite(dev_pwrite),
  .dev_paddr(dev_paddr), .dev_pwdata(dev_pwdata), .dev_prdata(dev_prdata),
  .dev_pready(dev_pready));

// ==== tb/dev_model.sv ====
// behavioural usb endpoint device seen through its registers
`timescale 1ns/100ps
module dev_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb from the controller
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ep_host_pkg::ADDR_W-1:0] paddr,
  input wire logic [ep_host_pkg::DATA_W-1:0] pwdata,
  output logic [ep_host_pkg::DATA_W-1:0] prdata,
  output logic pready,
  // test control and interrupt
  input wire logic slow,
  output logic irq
);
  import ep_host_pkg::*;
  logic [7:0] csr [8];
  logic [7:0] setup_q [$];
  logic [7:0] sent [$];
  int pkts [$];
  int wait_cnt;
  int ack_cnt;
  int cnt;
  logic [2:0] ep;
  assign ep = 3'((paddr - DEV_CSR_BASE) >> 2);
  // no stall, no out traffic, one clock: the controller uses none of them
  // interrupt while any completion or setup flag stands
  always_comb begin
    irq = 1'b0;
    foreach (csr[i]) irq |= csr[i][0] | csr[i][2];
  end
  // register access; slow mode adds three wait cycles
  always @(posedge clk_sys) begin
    pready <= 1'b0;
    prdata <= ~prdata; // released bus never keeps its last value
    if (!rst_n) begin
      prdata <= 32'h0;
      wait_cnt <= 0;
      ack_cnt <= 0;
      cnt <= 0;
      foreach (csr[i]) csr[i] <= 8'h00;
    end else begin
      if (psel && penable && !pready) begin
        if (slow && wait_cnt < 3) wait_cnt <= wait_cnt + 1;
        else begin
          wait_cnt <= 0;
          pready <= 1'b1;
          if (paddr < DEV_FDR_BASE && pwrite) csr[ep] <= pwdata[7:0];
          else if (paddr < DEV_FDR_BASE) prdata <= {24'h0, csr[ep]};
          else if (pwrite) begin
            sent.push_back(pwdata[7:0]);
            cnt <= cnt + 1;
          end else prdata <= {24'h0, setup_q.pop_front()};
        end
      end
      // host naks until the packet has waited, then acks it
      foreach (csr[i]) if (csr[i][TX_PACKET_READY_BIT]) begin
        ack_cnt <= ack_cnt + 1;
        if (ack_cnt == 20) begin
          csr[i][TX_COMPLETE_BIT] <= 1'b1;
          csr[i][TX_PACKET_READY_BIT] <= 1'b0;
          pkts.push_back(cnt);
          cnt <= 0;
          ack_cnt <= 0;
        end
      end
    end
  end
  // host setup packet, acked without firmware help
  task automatic inject(input logic [2:0] e, input logic [63:0] b);
    for (int i = 0; i < SETUP_BYTES; i++) setup_q.push_back(b[8*i +: 8]);
    csr[e][SETUP_RECEIVED_BIT] = 1'b1;
  endtask : inject
endmodule : dev_model

// ==== tb/ep_host_ctrl_tb_top.sv ====
// self-checking bench for the endpoint host controller
`timescale 1ns/100ps
module ep_host_ctrl_tb_top;
  import ep_host_pkg::*;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] wd;
    logic [31:0] exp;
    logic err;
  } row_type;
  logic clk_sys = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr, slow;
  logic [11:0] paddr, dev_paddr;
  logic [31:0] pwdata, prdata, dev_pwdata, dev_prdata;
  logic dev_psel, dev_penable, dev_pwrite, dev_pready;
  int err_total = 0;
  int total_checks = 0;
  // write then read back; unmapped and read-only places included
  row_type rows [10] = '{
    '{1'b0, STAT_OFFSET, 32'h0, 32'h0, 1'b0},
    '{1'b1, LEN_OFFSET, 32'h64, 32'h40, 1'b0},
    '{1'b1, LEN_OFFSET, 32'h3, 32'h3, 1'b0},
    '{1'b1, 12'h100, 32'h11, 32'h11, 1'b0},
    '{1'b1, 12'h104, 32'h22, 32'h22, 1'b0},
    '{1'b1, 12'h108, 32'h33, 32'h33, 1'b0},
    '{1'b1, 12'h020, 32'h5, 32'h0, 1'b1},
    '{1'b1, SETUP_LO_OFFSET, 32'h5, 32'h0, 1'b0},
    '{1'b1, CTRL_OFFSET, 32'h3, 32'h3, 1'b0},
    '{1'b1, CTRL_OFFSET, 32'h0, 32'h0, 1'b0}};
  ep_host_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_psel(dev_psel), .dev_penable(dev_penable), .dev_pwrite(dev_pwrite),
    .dev_paddr(dev_paddr), .dev_pwdata(dev_pwdata),
    .dev_prdata(dev_prdata), .dev_pready(dev_pready));
  dev_model dev_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(dev_psel),
    .penable(dev_penable), .pwrite(dev_pwrite), .paddr(dev_paddr),
    .pwdata(dev_pwdata), .prdata(dev_prdata), .pready(dev_pready),
    .slow(slow), .irq());
  always #20 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 100);
    // a transfer that never ends counts against the run
    if (pready !== 1'b1) begin
      err_total++;
      $display("Error pready expected 1 seen %b", pready);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // poll the status word until one flag is seen
  task automatic wait_stat(input int b);
    logic [31:0] r;
    logic e;
    int n;
    r = 32'h0;
    n = 0;
    while (r[b] !== 1'b1 && n < 300) begin
      apb(1'b0, STAT_OFFSET, 32'h0, r, e);
      n++;
    end
    chk("status flag", 32'h1, {31'h0, r[b]});
  endtask : wait_stat
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    complete_run();
  end
  initial begin
    logic [31:0] r;
    logic e;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slow = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        apb(1'b1, rows[i].addr, rows[i].wd, r, e);
        chk("write err", {31'h0, rows[i].err}, {31'h0, e});
      end
      apb(1'b0, rows[i].addr, 32'h0, r, e);
      // sequencer state field moves on its own
      if (rows[i].addr == STAT_OFFSET) r = r & 32'hff;
      chk("read data", rows[i].exp, r);
      chk("read err", {31'h0, rows[i].err}, {31'h0, e});
    end
    // setup packet on endpoint 0
    dev_u.inject(3'h0, 64'h8877665544332211);
    wait_stat(STAT_SETUP_BIT);
    apb(1'b0, SETUP_LO_OFFSET, 32'h0, r, e);
    chk("setup lo", 32'h44332211, r);
    apb(1'b0, SETUP_HI_OFFSET, 32'h0, r, e);
    chk("setup hi", 32'h88776655, r);
    chk("dev setup", 32'h0, {31'h0, dev_u.csr[0][2]});
    apb(1'b1, STAT_OFFSET, 32'h2, r, e);
    // three byte packet against a slow device
    slow <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h100, r, e);
    wait_stat(STAT_DONE_BIT);
    chk("sent count", 32'h3, 32'(dev_u.sent.size()));
    foreach (dev_u.sent[i])
      chk("sent byte", 32'(8'h11 * (i + 1)), {24'h0, dev_u.sent[i]});
    chk("dev done", 32'h0, {31'h0, dev_u.csr[0][0]});
    chk("dev ready", 32'h0, {31'h0, dev_u.csr[0][4]});
    // go on a two-bank endpoint is refused
    apb(1'b1, STAT_OFFSET, 32'h4, r, e);
    apb(1'b1, CTRL_OFFSET, 32'h101, r, e);
    apb(1'b0, STAT_OFFSET, 32'h0, r, e);
    chk("refused", 32'h8, r & 32'h1f);
    // zero length status packet
    apb(1'b1, STAT_OFFSET, 32'h8, r, e);
    apb(1'b1, LEN_OFFSET, 32'h0, r, e);
    apb(1'b1, CTRL_OFFSET, 32'h100, r, e);
    wait_stat(STAT_DONE_BIT);
    chk("packets", 32'h2, 32'(dev_u.pkts.size()));
    chk("zero length", 32'h0, 32'(dev_u.pkts[1]));
    // second go queued behind a packet awaiting its ack
    apb(1'b1, STAT_OFFSET, 32'h4, r, e);
    apb(1'b1, CTRL_OFFSET, 32'h100, r, e);
    wait (dev_u.csr[0][TX_PACKET_READY_BIT] === 1'b1);
    @(posedge clk_sys);
    apb(1'b1, CTRL_OFFSET, 32'h100, r, e);
    apb(1'b0, STAT_OFFSET, 32'h0, r, e);
    chk("queued", 32'h11, r & 32'h1f);
    wait_stat(STAT_DONE_BIT);
    chk("packets", 32'h4, 32'(dev_u.pkts.size()));
    chk("dev done", 32'h0, {31'h0, dev_u.csr[0][0]});
    // reset in mid-run clears the status word
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, STAT_OFFSET, 32'h0, r, e);
    chk("stat reset", 32'h0, r & 32'hff);
    complete_run();
  end
endmodule : ep_host_ctrl_tb_top
